// ### ana_advertise_regs.sv
/*
 * per-port advertisement registers for the two copper ports, the
 * read-only partner status bytes of all four ports, and the pause
 * resolution that feeds the mac flow control.
 * assumes the management port engine presents decoded byte accesses
 * on the register port, synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ana_advertise_regs
    import ana_pkg::*;
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       RESET_N_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic       REG_WR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_RD_I,
    output logic      [7:0] REG_RDATA_O,
    input  wire logic [5:0] PARTNER_STATUS_P1_I,
    input  wire logic [5:0] PARTNER_STATUS_P2_I,
    input  wire logic [5:0] PARTNER_STATUS_P3_I,
    input  wire logic [5:0] PARTNER_STATUS_P4_I,
    input  wire logic [1:0] LINK_FULL_DUPLEX_I,
    output logic      [5:0] ADVERTISE_P3_O,
    output logic      [5:0] ADVERTISE_P4_O,
    output logic      [1:0] TX_PAUSE_EN_O,
    output logic      [1:0] RX_PAUSE_EN_O
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // status byte: fiber flag, reserved zero, partner pause and speeds
    function automatic logic [7:0] status_byte(input logic fiber, input logic [5:0] partner);
        logic [7:0] b;
        b = 8'h00;
        b[ANA_BIT_FIBER] = fiber;
        b[ANA_ADV_W-1:0] = partner;
        return b;
    endfunction

    // returns {tx, rx}; pause only matters on a full-duplex link
    function automatic logic [1:0] resolve_pause(input logic [5:0] loc,
                                                 input logic [5:0] par,
                                                 input logic fdx);
        logic [1:0] r;
        r = 2'h0;
        if (fdx) begin
            if (loc[ANA_BIT_SYM] && par[ANA_BIT_SYM]) begin
                r = 2'h3;
            end else if (!loc[ANA_BIT_SYM] && loc[ANA_BIT_ASYM]
                         && par[ANA_BIT_SYM] && par[ANA_BIT_ASYM]) begin
                r = 2'h2; // transmit only toward partner
            end else if (loc[ANA_BIT_SYM] && loc[ANA_BIT_ASYM]
                         && !par[ANA_BIT_SYM] && par[ANA_BIT_ASYM]) begin
                r = 2'h1; // receive only toward local
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ana_state_type s_q;
    ana_state_type s_d;
    logic [1:0]    res_p3;
    logic [1:0]    res_p4;

    always_comb begin
        s_d = s_q;
        res_p3 = resolve_pause(s_q.adv_p3, PARTNER_STATUS_P3_I, LINK_FULL_DUPLEX_I[0]);
        res_p4 = resolve_pause(s_q.adv_p4, PARTNER_STATUS_P4_I, LINK_FULL_DUPLEX_I[1]);
        s_d.tx_pause = {res_p4[1], res_p3[1]};
        s_d.rx_pause = {res_p4[0], res_p3[0]};

        // top two bits are dropped, so they ignore writes
        if (REG_WR_I) begin
            if (REG_ADDR_I == ANA_OFS_ADV_P3) begin
                s_d.adv_p3 = REG_WDATA_I[ANA_ADV_W-1:0];
            end
            if (REG_ADDR_I == ANA_OFS_ADV_P4) begin
                s_d.adv_p4 = REG_WDATA_I[ANA_ADV_W-1:0];
            end
        end

        // read data holds until the next read strobe
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                ANA_OFS_ADV_P3: s_d.rdata = {2'h0, s_q.adv_p3};
                ANA_OFS_ADV_P4: s_d.rdata = {2'h0, s_q.adv_p4};
                ANA_OFS_STATUS_P1: s_d.rdata = status_byte(1'b1, PARTNER_STATUS_P1_I);
                ANA_OFS_STATUS_P2: s_d.rdata = status_byte(1'b1, PARTNER_STATUS_P2_I);
                ANA_OFS_STATUS_P3: s_d.rdata = status_byte(1'b0, PARTNER_STATUS_P3_I);
                ANA_OFS_STATUS_P4: s_d.rdata = status_byte(1'b0, PARTNER_STATUS_P4_I);
                ANA_OFS_STATUS_RSV: s_d.rdata = 8'h00;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            s_q.adv_p3 <= ANA_ADV_RESET;
            s_q.adv_p4 <= ANA_ADV_RESET;
            s_q.rdata <= ANA_RDATA_RESET;
            s_q.tx_pause <= 2'h0;
            s_q.rx_pause <= 2'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // each speed bit passes straight to negotiation: 1 offers, 0 withholds
    assign ADVERTISE_P3_O = s_q.adv_p3;
    assign ADVERTISE_P4_O = s_q.adv_p4;
    assign REG_RDATA_O = s_q.rdata;
    assign TX_PAUSE_EN_O = s_q.tx_pause;
    assign RX_PAUSE_EN_O = s_q.rx_pause;

endmodule

`default_nettype wire

// ### ana_advertise_regs_checker.sv
/* port assertions for the advertisement slice.
   assumes one core clock and the active-low async reset. */
`timescale 1ns/1ps
`default_nettype none
module ana_advertise_regs_checker (
    input wire logic       CORE_CLK_I, RESET_N_I, REG_WR_I, REG_RD_I,
    input wire logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O,
    input wire logic [5:0] PARTNER_STATUS_P1_I, PARTNER_STATUS_P3_I,
    input wire logic [5:0] ADVERTISE_P3_O, ADVERTISE_P4_O,
    input wire logic [1:0] LINK_FULL_DUPLEX_I, TX_PAUSE_EN_O, RX_PAUSE_EN_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    wire logic w3 = REG_WR_I && REG_ADDR_I == 8'h37;
    wire logic fd = LINK_FULL_DUPLEX_I[0];
    a_write_port3: assert property (w3 |=> ADVERTISE_P3_O == $past(REG_WDATA_I[5:0]))
        else $error("port 3 write lost");
    a_write_port4: assert property (REG_WR_I && REG_ADDR_I == 8'h47 |=> ADVERTISE_P4_O ==
        $past(REG_WDATA_I[5:0])) else $error("port 4 write lost");
    a_adv_hold: assert property (!w3 |=> $stable(ADVERTISE_P3_O))
        else $error("port 3 changed without write");
    a_adv_hold4: assert property (!(REG_WR_I && REG_ADDR_I == 8'h47) |=> $stable(ADVERTISE_P4_O))
        else $error("port 4 changed without write");
    a_read_adv: assert property (REG_RD_I && REG_ADDR_I == 8'h37 |=> REG_RDATA_O ==
        {2'h0, $past(ADVERTISE_P3_O)}) else $error("bad advert read");
    a_read_status: assert property (REG_RD_I && REG_ADDR_I == 8'h18 |=> REG_RDATA_O ==
        {2'h2, $past(PARTNER_STATUS_P1_I)}) else $error("bad status read");
    a_read_rsvd: assert property (REG_RD_I && REG_ADDR_I == 8'h58 |=> REG_RDATA_O == 8'h00)
        else $error("reserved slot not zero");
    a_pause_sym: assert property (fd && ADVERTISE_P3_O[4] && PARTNER_STATUS_P3_I[4]
        |=> TX_PAUSE_EN_O[0] && RX_PAUSE_EN_O[0]) else $error("symmetric pause off");
    a_pause_half: assert property (!fd |=> !TX_PAUSE_EN_O[0] && !RX_PAUSE_EN_O[0])
        else $error("pause on in half duplex");
    c_write: cover property (w3);
    c_rsvd: cover property (REG_RD_I && REG_ADDR_I == 8'h58);
    c_tx_only: cover property (TX_PAUSE_EN_O[0] && !RX_PAUSE_EN_O[0]);
endmodule
bind ana_advertise_regs ana_advertise_regs_checker i_chk (.*);
`default_nettype wire

// ### ana_link_partner.sv
/* link partner stand-in: ability words per port and link duplex.
   assumes the bench sets one ability word for all ports. */
`timescale 1ns/1ps
`default_nettype none
module ana_link_partner (
    input  wire logic [5:0] caps_i,
    input  wire logic       fdx_i,
    output logic      [5:0] p1_o, p2_o, p3_o, p4_o,
    output logic      [1:0] fdx_o
);
    // pause code on top, abilities below
    assign p1_o = caps_i;
    assign p3_o = caps_i;
    // complement on 2 and 4 so crossed ports show up
    assign p2_o = ~caps_i;
    assign p4_o = ~caps_i;
    assign fdx_o = {2{fdx_i}};
endmodule
`default_nettype wire

// ### ana_pkg.sv
/*
 * constants for the auto-negotiation advertisement register slice:
 * offsets, field positions, reset values and pause codes.
 * assumes an 8-bit register space reached through the management port.
 */
package ana_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ANA_OFS_STATUS_P1 = 8'h18;
    localparam logic [7:0] ANA_OFS_STATUS_P2 = 8'h28;
    localparam logic [7:0] ANA_OFS_STATUS_P3 = 8'h38;
    localparam logic [7:0] ANA_OFS_STATUS_P4 = 8'h48;
    localparam logic [7:0] ANA_OFS_STATUS_RSV = 8'h58;
    localparam logic [7:0] ANA_OFS_ADV_P3 = 8'h37;
    localparam logic [7:0] ANA_OFS_ADV_P4 = 8'h47;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ANA_BIT_10HD = 0;
    localparam int ANA_BIT_10FD = 1;
    localparam int ANA_BIT_100HD = 2;
    localparam int ANA_BIT_100FD = 3;
    localparam int ANA_BIT_SYM = 4;
    localparam int ANA_BIT_ASYM = 5;
    localparam int ANA_BIT_FIBER = 7;
    localparam int ANA_ADV_W = 6;

    // ----------------------------------------------------------------
    // pause codes and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] ANA_PAUSE_NONE = 2'h0;
    localparam logic [1:0] ANA_PAUSE_SYM = 2'h1;
    localparam logic [1:0] ANA_PAUSE_ASYM_PARTNER = 2'h2;
    localparam logic [1:0] ANA_PAUSE_BOTH = 2'h3;
    localparam logic [3:0] ANA_SPEED_RESET = 4'hf;
    localparam logic [5:0] ANA_ADV_RESET = {ANA_PAUSE_BOTH, ANA_SPEED_RESET};
    localparam logic [7:0] ANA_RDATA_RESET = 8'h00;

    typedef struct packed {
        logic [5:0] adv_p3;
        logic [5:0] adv_p4;
        logic [7:0] rdata;
        logic [1:0] tx_pause;
        logic [1:0] rx_pause;
    } ana_state_type;

endpackage

// ### tb_ana_advertise_regs.sv
/* self-checking bench for the advertisement slice.
   assumes the partner model and checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb_ana_advertise_regs;
    typedef struct packed {logic [7:0] a, w, e;} ana_row_type;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, fdx = 0;
    logic [7:0] addr = 0, wd = 0;
    logic [5:0] caps = 0;
    wire logic [7:0] rdat;
    wire logic [5:0] p1, p2, p3, p4, a3, a4;
    wire logic [1:0] fd, tx, rx;
    int n_errors = 0, n_compared = 0;
    ana_row_type rows [6] = '{'{8'h37, 8'h00, 8'h00}, '{8'h37, 8'h1f, 8'h1f},
        '{8'h47, 8'h34, 8'h34}, '{8'h47, 8'h02, 8'h02}, '{8'h47, 8'h01, 8'h01},
        '{8'h37, 8'he8, 8'h28}};
    always #50 clk = ~clk;
    ana_link_partner i_lp (.caps_i(caps), .fdx_i(fdx), .p1_o(p1), .p2_o(p2), .p3_o(p3),
        .p4_o(p4), .fdx_o(fd));
    ana_advertise_regs i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WR_I(wr), .REG_WDATA_I(wd), .REG_RD_I(rd), .REG_RDATA_O(rdat),
        .PARTNER_STATUS_P1_I(p1), .PARTNER_STATUS_P2_I(p2), .PARTNER_STATUS_P3_I(p3),
        .PARTNER_STATUS_P4_I(p4), .LINK_FULL_DUPLEX_I(fd), .ADVERTISE_P3_O(a3),
        .ADVERTISE_P4_O(a4), .TX_PAUSE_EN_O(tx), .RX_PAUSE_EN_O(rx));
    task chk(input string nm, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr_reg(input logic [7:0] a, d);
        @(posedge clk) #1;
        addr = a; wd = d; wr = 1;
        @(posedge clk) #1;
        wr = 0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clk) #1;
        addr = a; rd = 1;
        @(posedge clk) #1;
        rd = 0;
    endtask
    // pause outputs are registered, so give them two edges
    task pause_chk(input logic [7:0] adv, input logic [5:0] c, input logic f, input logic [7:0] e);
        wr_reg(8'h37, adv);
        caps = c; fdx = f;
        repeat (2) @(posedge clk) #1;
        chk("pause", e, {6'h0, tx[0], rx[0]});
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge clk);
        chk("adv3", 8'h3f, {2'h0, a3});
        chk("adv4", 8'h3f, {2'h0, a4});
        chk("rdat", 8'h00, rdat);
        #1 rst_n = 1;
        rd_reg(8'h37);
        chk("rd37", 8'h3f, rdat);
        $display("reset test done");
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a);
            chk("rdback", rows[i].e, rdat);
            chk("adv", rows[i].e, {2'h0, (rows[i].a == 8'h37) ? a3 : a4});
        end
        $display("table test done");
        wr_reg(8'h38, 8'h3f);
        chk("ro write", 8'h28, {2'h0, a3});
        caps = 6'h2a;
        rd_reg(8'h18);
        chk("st1", 8'haa, rdat);
        rd_reg(8'h48);
        chk("st4", 8'h15, rdat);
        rd_reg(8'h28);
        chk("st2", 8'h95, rdat);
        rd_reg(8'h38);
        chk("st3", 8'h2a, rdat);
        rd_reg(8'h58);
        chk("rsv", 8'h00, rdat);
        $display("status test done");
        pause_chk(8'h30, 6'h30, 1'b1, 8'h03);
        pause_chk(8'h20, 6'h30, 1'b1, 8'h02);
        pause_chk(8'h30, 6'h20, 1'b1, 8'h01);
        pause_chk(8'h30, 6'h30, 1'b0, 8'h00);
        $display("pause test done");
        print_verdict;
    end
endmodule
`default_nettype wire
